// ---- logic/flash_host_pkg.sv ----
// Notes on behaviour
// - Read: select and gate low, strobe high
// - Write: strobe and select low, gate high
// - Host does not reissue operations cut by reset
// - Host waits recovery time before reading
package flash_host_pkg;
    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned ACCESS_TIME_NS = 90;
    localparam int unsigned SETUP_TIME_NS = 50;
    localparam int unsigned WRITE_PULSE_NS = 50;
    localparam int unsigned RESET_PULSE_NS = 500;
    localparam int unsigned RESET_HIGH_NS = 50;
    localparam int unsigned SLEEP_MARGIN_NS = 30;
    // Least times round up, at least one cycle
    localparam int unsigned ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETUP_CYC = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RECOVER_CYC = (RESET_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Counter width
    localparam int unsigned CNT_W = 8;
    // ==========================================================
    // Widths
    // ==========================================================
    localparam int unsigned ADDR_W = 20;
    localparam int unsigned DATA_W = 8;
    // ==========================================================
    // Host operations
    // ==========================================================
    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_RESET = 2'h2,
        OP_UNPROTECT = 2'h3
    } op_t;
endpackage

// ---- logic/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import flash_host_pkg::*;
#(
    parameter int unsigned WIDTH = 9,
    // Idle level of each pin, so that reset shows no false change
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Pins in, synchronised out
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_t;
    sync_t s_reg;
    sync_t s_next;

    // ==========================================================
    // Two-stage synchroniser
    // ==========================================================
    // Next state
    always_comb
    begin
        s_next.first = pin_in;
        s_next.second = s_reg.first;
    end

    // Registers
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_reg <= '{first: RESET_VAL, second: RESET_VAL};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign pin_out = s_reg.second;
endmodule
`default_nettype wire

// ---- logic/flash_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_host
    import flash_host_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Request port
    input wire logic req_valid,
    input wire logic [1:0] req_op,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic dev_busy,
    // Flash pins
    output logic chip_select_n,
    output logic output_gate_n,
    output logic write_strobe_n,
    output logic init_pin_n,
    output logic high_voltage_en,
    output logic [ADDR_W-1:0] address_lines,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic done_flag_pin
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SETUP = 3'h1,
        ST_ACTIVE = 3'h3,
        ST_DONE = 3'h2,
        ST_RESET = 3'h6,
        ST_RECOVER = 3'h7
    } state_t;

    typedef struct packed {
        state_t state;
        op_t op;
        logic [CNT_W-1:0] cnt;
        logic ready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic busy;
        logic cs_n;
        logic oe_n;
        logic we_n;
        logic rst_n;
        logic hv;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic doe;
    } host_t;

    host_t h_reg;
    host_t h_next;
    logic [DATA_W:0] sync_out;

    // Counts must fit the counter, read count includes synchroniser
    if (RESET_CYC >= (1 << CNT_W) || (ACCESS_CYC + 2) >= (1 << CNT_W))
    begin : g_cnt_chk
        $error("count too wide for counter");
    end

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    // Done flag idles high, data idles low
    pin_sync #(.WIDTH(DATA_W + 1), .RESET_VAL({1'b1, {DATA_W{1'b0}}})) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pin_in({done_flag_pin, data_in}),
        .pin_out(sync_out)
    );

    // Load a count for a phase
    function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
        cyc = CNT_W'(n);
    endfunction

    // ==========================================================
    // Bus sequencer
    // ==========================================================
    // Next state
    always_comb
    begin
        h_next = h_reg;
        h_next.rvalid = 1'b0;
        h_next.busy = ~sync_out[DATA_W];
        if (h_reg.cnt != '0)
            h_next.cnt = h_reg.cnt - 1'b1;
        case (h_reg.state)
            ST_IDLE:
            begin
                if (req_valid && h_reg.ready)
                begin
                    h_next.ready = 1'b0;
                    h_next.op = op_t'(req_op);
                    h_next.addr = req_addr;
                    h_next.dout = req_wdata;
                    h_next.hv = 1'b0;
                    case (op_t'(req_op))
                        OP_RESET, OP_UNPROTECT:
                        begin
                            // Float and hold chip deselected during reset
                            h_next.cs_n = 1'b1;
                            h_next.oe_n = 1'b1;
                            h_next.we_n = 1'b1;
                            h_next.doe = 1'b0;
                            h_next.rst_n = 1'b0;
                            h_next.hv = (op_t'(req_op) == OP_UNPROTECT);
                            h_next.cnt = cyc(RESET_CYC);
                            h_next.state = ST_RESET;
                        end
                        default:
                        begin
                            // Address settles with select; strobe follows
                            h_next.cs_n = 1'b0;
                            h_next.doe = (op_t'(req_op) == OP_WRITE);
                            h_next.cnt = cyc(SETUP_CYC);
                            h_next.state = ST_SETUP;
                        end
                    endcase
                end
            end
            ST_SETUP:
            begin
                if (h_reg.cnt <= 1)
                begin
                    if (h_reg.op == OP_WRITE)
                    begin
                        h_next.oe_n = 1'b1;
                        h_next.we_n = 1'b0;
                        h_next.cnt = cyc(WRITE_CYC);
                    end
                    else
                    begin
                        h_next.we_n = 1'b1;
                        h_next.oe_n = 1'b0;
                        // Extra two cycles cover the synchroniser
                        h_next.cnt = cyc(ACCESS_CYC + 2);
                    end
                    h_next.state = ST_ACTIVE;
                end
            end
            ST_ACTIVE:
            begin
                if (h_reg.cnt <= 1)
                begin
                    if (h_reg.op == OP_READ)
                    begin
                        h_next.rdata = sync_out[DATA_W-1:0];
                        h_next.rvalid = 1'b1;
                    end
                    // Write ends on strobe rise, select later
                    h_next.we_n = 1'b1;
                    h_next.oe_n = 1'b1;
                    h_next.state = ST_DONE;
                end
            end
            ST_DONE:
            begin
                // Deselect: standby, data released
                h_next.cs_n = 1'b1;
                h_next.doe = 1'b0;
                h_next.ready = 1'b1;
                h_next.state = ST_IDLE;
            end
            ST_RESET:
            begin
                if (h_reg.cnt <= 1)
                begin
                    h_next.rst_n = 1'b1;
                    h_next.hv = 1'b0;
                    h_next.cnt = cyc(RECOVER_CYC);
                    h_next.state = ST_RECOVER;
                end
            end
            ST_RECOVER:
            begin
                // Hold off requests for the recovery time and busy
                if (h_reg.cnt == '0 && sync_out[DATA_W])
                begin
                    h_next.ready = 1'b1;
                    h_next.state = ST_IDLE;
                end
            end
            default:
            begin
                h_next.state = ST_IDLE;
            end
        endcase
    end

    // Registers
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            h_reg <= '{state: ST_IDLE, op: OP_READ, cnt: '0, ready: 1'b1, rvalid: 1'b0,
                       rdata: '0, busy: 1'b0, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                       rst_n: 1'b1, hv: 1'b0, addr: '0, dout: '0, doe: 1'b0};
        end
        else
        begin
            h_reg <= h_next;
        end
    end

    // Outputs straight from flip-flops
    assign req_ready = h_reg.ready;
    assign rsp_valid = h_reg.rvalid;
    assign rsp_rdata = h_reg.rdata;
    assign dev_busy = h_reg.busy;
    assign chip_select_n = h_reg.cs_n;
    assign output_gate_n = h_reg.oe_n;
    assign write_strobe_n = h_reg.we_n;
    assign init_pin_n = h_reg.rst_n;
    assign high_voltage_en = h_reg.hv;
    assign address_lines = h_reg.addr;
    assign data_out = h_reg.dout;
    assign data_oe = h_reg.doe;

    // ==========================================================
    // Checks
    // ==========================================================
    chk_read_strobes: assert property (@(posedge mclk) disable iff (sys_rst)
        !output_gate_n |-> (!chip_select_n && write_strobe_n && init_pin_n))
        else $error("read strobes illegal");
    chk_write_strobes: assert property (@(posedge mclk) disable iff (sys_rst)
        !write_strobe_n |-> (!chip_select_n && output_gate_n && data_oe))
        else $error("write strobes illegal");
    chk_reset_idle: assert property (@(posedge mclk) disable iff (sys_rst)
        !init_pin_n |-> (chip_select_n && output_gate_n && !data_oe))
        else $error("bus active in reset");
    chk_reset_width: assert property (@(posedge mclk) disable iff (sys_rst)
        $fell(init_pin_n) |-> !init_pin_n [*5])
        else $error("reset pulse short");
    chk_recover_wait: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(init_pin_n) |-> !req_ready [*2])
        else $error("ready before recovery");
    chk_gate_float: assert property (@(posedge mclk) disable iff (sys_rst)
        !output_gate_n |-> !data_oe)
        else $error("contention on data");
    chk_write_end: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(write_strobe_n) |-> !chip_select_n ##1 chip_select_n)
        else $error("write end order");
    chk_hv_reset: assert property (@(posedge mclk) disable iff (sys_rst)
        high_voltage_en |-> !init_pin_n)
        else $error("high voltage outside reset");
    chk_read_answer: assert property (@(posedge mclk) disable iff (sys_rst)
        $fell(output_gate_n) |-> ##3 rsp_valid)
        else $error("read answer late");
    cov_read: cover property (@(posedge mclk) rsp_valid);
    cov_write: cover property (@(posedge mclk) $rose(write_strobe_n));
    cov_reset: cover property (@(posedge mclk) $rose(init_pin_n));
endmodule
`default_nettype wire

// ---- bench/flash_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_model
    import flash_host_pkg::*;
#(
    parameter logic [7:0] ID_CODE = 8'h5C, // Arbitrary value
    parameter int T_PROG = 60,
    parameter int T_ABORT = 40
)
(
    // Control pins
    input wire logic chip_select_n,
    input wire logic output_gate_n,
    input wire logic write_strobe_n,
    input wire logic init_pin_n,
    input wire logic high_voltage_en,
    // Address and data
    input wire logic [ADDR_W-1:0] address_lines,
    input wire logic [DATA_W-1:0] data_out,
    output logic [DATA_W-1:0] data_in,
    output logic done_flag_pin
);
    // ======================================
    // Array and command latches
    // ======================================
    logic [7:0] mem [256];
    logic [1:0] mode = 2'h0;
    logic [7:0] pdat = 8'h00;
    logic [7:0] paddr = 8'h00;
    logic [7:0] val;
    logic [7:0] last = 8'h00;
    logic prog_run = 1'b0;
    logic unprot;
    int busy = 0;
    wire wr_act = !chip_select_n && !write_strobe_n && output_gate_n && init_pin_n;
    wire drive = !chip_select_n && !output_gate_n && init_pin_n;
    initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5A;
    // Embedded timer, runs every 50 ns regardless of select
    always #50
    begin
        if (busy > 0) busy = busy - 1;
        if (busy == 0 && prog_run)
        begin
            mem[paddr] = pdat;
            prog_run = 1'b0;
        end
    end
    assign done_flag_pin = (busy == 0);
    assign unprot = high_voltage_en;
    // Capture at end of write cycle
    always @(negedge wr_act)
    begin
        if (busy == 0 && mode == 2'h2)
        begin
            paddr = address_lines[7:0];
            pdat = data_out;
            prog_run = 1'b1;
            busy = T_PROG;
            mode = 2'h0;
        end
        // Sector erase: upper index bits pick the sector of this small array
        else if (busy == 0 && mode == 2'h3 && data_out == 8'h30)
        begin
            for (int i = 0; i < 256; i++)
                if (i[7:4] == address_lines[7:4]) mem[i] = 8'hFF;
            paddr = address_lines[7:0];
            pdat = 8'hFF;
            prog_run = 1'b1;
            busy = T_PROG;
            mode = 2'h0;
        end
        else if (busy == 0)
        begin
            mode = (data_out == 8'h90) ? 2'h1 : (data_out == 8'hA0) ? 2'h2 : 2'h0;
            if (data_out == 8'h80) mode = 2'h3;
        end
    end
    // Reset aborts, back to array
    always @(negedge init_pin_n)
    begin
        prog_run = 1'b0;
        mode = 2'h0;
        busy = (busy > 0) ? T_ABORT : 0;
    end
    // Read path, valid only while select and gate low, inverted last value otherwise
    always_comb
        if (prog_run) val = {~pdat[7], 7'h00};
        else if (mode == 2'h1) val = ID_CODE;
        else val = mem[address_lines[7:0]];
    always @(val or drive) if (drive) last = val;
    assign data_in = drive ? val : ~last;
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import flash_host_pkg::*;
    localparam logic [7:0] ID_CODE = 8'hC6; // Arbitrary value
    logic mclk, sys_rst, req_valid, req_ready, rsp_valid, dev_busy, hv_seen;
    logic [1:0] req_op;
    logic [19:0] req_addr, address_lines;
    logic [7:0] req_wdata, rsp_rdata, data_out, data_in;
    logic chip_select_n, output_gate_n, write_strobe_n, init_pin_n;
    logic high_voltage_en, data_oe, done_flag_pin;
    int failures = 0;
    int n_checks = 0;
    // ======================================
    // Instances
    // ======================================
    flash_host flash_host_i (.mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .dev_busy(dev_busy),
        .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
        .write_strobe_n(write_strobe_n), .init_pin_n(init_pin_n),
        .high_voltage_en(high_voltage_en), .address_lines(address_lines),
        .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
        .done_flag_pin(done_flag_pin));
    flash_model #(.ID_CODE(ID_CODE)) flash_model_i (.chip_select_n(chip_select_n),
        .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n),
        .init_pin_n(init_pin_n), .high_voltage_en(high_voltage_en),
        .address_lines(address_lines), .data_out(data_out), .data_in(data_in),
        .done_flag_pin(done_flag_pin));
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // ======================================
    // Shared tasks
    // ======================================
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic req(input logic [1:0] op, input logic [19:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_wdata <= d;
        @(posedge mclk);
        while (req_ready !== 1'b1 && n < 300)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= 300) failures++;
        req_valid <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        int n;
        n = 0;
        req(2'h0, a, 8'h00);
        while (rsp_valid !== 1'b1 && n < 20)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= 20) failures++;
        check("read data", e, rsp_rdata);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        // Done flag reaches dev_busy only after synchroniser and register
        repeat (6) @(posedge mclk);
        while (!(req_ready === 1'b1 && dev_busy === 1'b0) && n < 400)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= 400) failures++;
    endtask
    // Pin levels of every bus cycle
    always @(posedge mclk)
    begin
        if (!chip_select_n && !output_gate_n)
            check("read pins", 8'h01, {7'h0, write_strobe_n & init_pin_n});
        if (!chip_select_n && !write_strobe_n)
            check("write pins", 8'h01, {7'h0, output_gate_n});
        if (flash_model_i.unprot === 1'b1) hv_seen <= 1'b1;
    end
    // ======================================
    // Scenarios
    // ======================================
    task automatic t_read;
        rd(20'h00010, 8'h4A);
        rd(20'hFFFFF, 8'hA5);
        $display("test read done");
    endtask
    task automatic t_prog;
        req(2'h1, 20'h00000, 8'hA0);
        req(2'h1, 20'h00033, 8'hC3);
        rd(20'h00033, 8'h00);
        wait_idle();
        rd(20'h00033, 8'hC3);
        $display("test program done");
    endtask
    task automatic t_ident;
        req(2'h1, 20'h00000, 8'h90);
        rd(20'h00000, ID_CODE);
        req(2'h1, 20'h00000, 8'hF0);
        rd(20'h00000, 8'h5A);
        $display("test ident done");
    endtask
    task automatic t_erase;
        req(2'h1, 20'h00000, 8'h80);
        req(2'h1, 20'h00025, 8'h30);
        rd(20'h00021, 8'h00);
        wait_idle();
        rd(20'h00021, 8'hFF);
        rd(20'h00031, 8'h6B);
        $display("test erase done");
    endtask
    task automatic t_reset;
        req(2'h1, 20'h00000, 8'hA0);
        req(2'h1, 20'h00044, 8'h11);
        req(2'h2, 20'h00000, 8'h00);
        repeat (4) @(posedge mclk);
        check("busy in reset", 8'h01, {7'h0, dev_busy});
        wait_idle();
        check("flag at ready", 8'h01, {7'h0, done_flag_pin});
        rd(20'h00044, 8'h1E);
        req(2'h1, 20'h00000, 8'hA0);
        req(2'h1, 20'h00044, 8'h11);
        wait_idle();
        rd(20'h00044, 8'h11);
        $display("test reset done");
    endtask
    task automatic t_unprot;
        req(2'h3, 20'h00000, 8'h00);
        wait_idle();
        check("high volt seen", 8'h01, {7'h0, hv_seen});
        check("high volt off", 8'h00, {7'h0, high_voltage_en});
        check("idle reset busy", 8'h00, {7'h0, dev_busy});
        rd(20'h00001, 8'h5B);
        $display("test unprotect done");
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge mclk);
        failures++;
        close_out();
    end
    initial
    begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req_op = 2'h0;
        req_addr = 20'h00000;
        req_wdata = 8'h00;
        hv_seen = 1'b0;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_read();
        t_prog();
        t_ident();
        t_erase();
        t_reset();
        t_unprot();
        close_out();
    end
endmodule
`default_nettype wire
